/* File: pkg/asfb_map.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the serial channel design files
`ifndef ASFB_MAP_SVH
`define ASFB_MAP_SVH
`define ASFB_OFS_BAUD 5'h00
`define ASFB_OFS_CTRL 5'h04
`define ASFB_OFS_STAT 5'h08
`define ASFB_OFS_MASK 5'h0c
`define ASFB_OFS_DATA 5'h10
`define ASFB_CH_SEL_BIT 5
`define ASFB_BAUD_RST 13'h0000
`define ASFB_CTRL_RST 9'h000
`define ASFB_STAT_RST 7'h00
`define ASFB_MASK_RST 7'h00
`define ASFB_C_TE 0
`define ASFB_C_RE 1
`define ASFB_C_NINE 2
`define ASFB_C_PE 3
`define ASFB_C_PT 4
`define ASFB_C_LOOPS 5
`define ASFB_C_RSRC 6
`define ASFB_C_SBK 7
`define ASFB_C_RIE 8
`define ASFB_S_RXF 0
`define ASFB_S_TXD 1
`define ASFB_S_PERR 2
`define ASFB_S_FERR 3
`define ASFB_S_OVR 4
`define ASFB_S_BRK 5
`define ASFB_S_WAKE 6
`define ASFB_S_RAF 8
`define ASFB_S_BUSY 9
`define ASFB_OVS_LAST 4'hf
`define ASFB_MID_SAMPLE 4'h7
`define ASFB_BITS_8 4'ha
`endif

/* File: pkg/asfb_pkg.sv */
// types shared by the serial channel top and its channel core
// assumes nothing beyond a SystemVerilog compiler
package asfb_pkg;
  typedef struct packed {
    logic [12:0] div;
    logic te;
    logic re;
    logic nine;
    logic pe;
    logic pt;
    logic sbk;
  } asfb_cfg_t;
  typedef struct packed {
    logic [8:0] data;
    logic perr;
    logic ferr;
    logic brk;
  } asfb_rx_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} asfb_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asfb_rx_st_t;
  // parity over the payload; top data bit carries parity
  function automatic logic asfb_par(input logic [8:0] d, input logic nine, input logic odd);
    return (^d[6:0]) ^ (nine & d[7]) ^ odd;
  endfunction
endpackage

/* File: logic/asfb_chan.sv */
// one serial channel: baud generator, transmitter and receiver
// assumes cfg stable during frames and rxd synchronous to pclk
`timescale 1ns/10ps
`include "asfb_map.svh"
module asfb_chan (
  input wire logic pclk,
  input wire logic presetn,
  input wire asfb_pkg::asfb_cfg_t cfg,
  input wire logic tx_load,
  input wire logic [8:0] tx_data,
  input wire logic rxd,
  output logic txd,
  output logic tx_busy,
  output logic tx_done,
  output asfb_pkg::asfb_rx_t rx_word,
  output logic rx_valid,
  output logic rx_active
);
  import asfb_pkg::*;
  logic gen_on_r;
  logic [12:0] bcnt_r;
  logic tick;
  asfb_tx_st_t tx_st_r;
  logic [10:0] tsh_r;
  logic [3:0] tsub_r, tbits_r;
  asfb_rx_st_t rx_st_r;
  logic [8:0] rsh_r;
  logic [3:0] rsub_r, rbits_r;
  logic [8:0] rx_pay;
  logic [10:0] frame;
  logic [3:0] nbits;

  // generator off until te/re first seen and while divisor is zero
  assign tick = gen_on_r && (cfg.div != 13'h0000) && (bcnt_r >= cfg.div - 13'h0001);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gen_on_r <= 1'b0;
    else if (cfg.te || cfg.re) gen_on_r <= 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bcnt_r <= 13'h0000;
    else if (!gen_on_r || tick) bcnt_r <= 13'h0000;
    else bcnt_r <= bcnt_r + 13'h0001;
  end

  // start 0, lsb first, optional parity in top bit, stop 1
  assign frame = cfg.nine ?
    {1'b1, cfg.pe ? asfb_par(tx_data, 1'b1, cfg.pt) : tx_data[8], tx_data[7:0], 1'b0} :
    {2'b11, cfg.pe ? asfb_par(tx_data, 1'b0, cfg.pt) : tx_data[7], tx_data[6:0], 1'b0};
  assign nbits = `ASFB_BITS_8 + {3'h0, cfg.nine};
  assign txd = (tx_st_r == TX_SHIFT) ? tsh_r[0] : 1'b1;
  assign tx_busy = (tx_st_r == TX_SHIFT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= TX_IDLE;
      tsh_r <= 11'h7ff;
      tsub_r <= 4'h0;
      tbits_r <= 4'h0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      case (tx_st_r)
        TX_IDLE: begin
          tsub_r <= 4'h0;
          tbits_r <= 4'h0;
          if (cfg.te && cfg.sbk && gen_on_r) begin
            tsh_r <= 11'h000;
            tx_st_r <= TX_SHIFT;
          end else if (tx_load) begin
            tsh_r <= frame;
            tx_st_r <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tick) begin
            tsub_r <= tsub_r + 4'h1;
            if (tsub_r == `ASFB_OVS_LAST) begin
              tsh_r <= {1'b1, tsh_r[10:1]};
              tbits_r <= tbits_r + 4'h1;
              if (tbits_r == nbits - 4'h1) begin
                tx_st_r <= TX_IDLE;
                tx_done <= 1'b1;
              end
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // 16x oversampling, resync on start edge, sample at bit centres
  assign rx_pay = cfg.nine ? rsh_r : {1'b0, rsh_r[8:1]};
  assign rx_active = (rx_st_r != RX_IDLE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= RX_IDLE;
      rsh_r <= 9'h000;
      rsub_r <= 4'h0;
      rbits_r <= 4'h0;
      rx_valid <= 1'b0;
      rx_word <= '0;
    end else begin
      rx_valid <= 1'b0;
      case (rx_st_r)
        RX_IDLE: begin
          rsub_r <= 4'h0;
          rbits_r <= 4'h0;
          if (cfg.re && tick && !rxd) rx_st_r <= RX_START;
        end
        RX_START: begin
          if (tick) begin
            rsub_r <= rsub_r + 4'h1;
            if (rsub_r == `ASFB_MID_SAMPLE) begin
              rsub_r <= 4'h0;
              rx_st_r <= rxd ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rsub_r <= rsub_r + 4'h1;
            if (rsub_r == `ASFB_OVS_LAST) begin
              rsh_r <= {rxd, rsh_r[8:1]};
              rbits_r <= rbits_r + 4'h1;
              if (rbits_r == nbits - 4'h3) rx_st_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rsub_r <= rsub_r + 4'h1;
            if (rsub_r == `ASFB_OVS_LAST) begin
              rx_st_r <= RX_IDLE;
              rx_valid <= 1'b1;
              rx_word.data <= rx_pay;
              rx_word.ferr <= !rxd;
              rx_word.brk <= !rxd && (rx_pay == 9'h000);
              rx_word.perr <= cfg.pe && (asfb_par(rx_pay, cfg.nine, cfg.pt) !=
                (cfg.nine ? rx_pay[8] : rx_pay[7]));
            end
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_baud_zero_off: assert property (cfg.div == 13'h0000 |-> !tick)
    else $error("baud tick with zero divisor");
  a_line_idle_high: assert property (tx_st_r == TX_IDLE |-> txd)
    else $error("tx line low while idle");
  a_start_bit_low: assert property ($rose(tx_busy) |-> !txd)
    else $error("frame did not open with a low start bit");
  a_lsb_goes_first: assert property
    (tx_load && tx_st_r == TX_IDLE && !cfg.sbk |=> tsh_r[1] == $past(tx_data[0]))
    else $error("first data bit is not the lsb");
  a_tx_parity_bit: assert property (tx_load && tx_st_r == TX_IDLE && !cfg.sbk && cfg.pe
    && !cfg.nine |=> tsh_r[8] == ^{$past(tx_data[6:0]), $past(cfg.pt)})
    else $error("transmitted parity bit wrong");
  a_break_is_ferr: assert property (rx_valid && rx_word.brk |-> rx_word.ferr)
    else $error("break reported without a low stop bit");
  a_tick_period: assert property (tick && cfg.div == 13'h0003 && $stable(cfg.div)
    |=> !tick ##1 !tick ##1 tick)
    else $error("divisor three does not tick every third clock");
  c_rx_frame: cover property (rx_valid && !rx_word.ferr);
  c_tx_frame: cover property (tx_done);
endmodule

/* File: logic/asfb_top.sv */
// two-channel async serial block with apb register slave and interrupt
// assumes apb master in pclk domain; pins synchronous to pclk
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "asfb_map.svh"
// Operation
// - frame is one start, eight or nine data bits, one stop, nrz
// - line rests high while idle
// - each character opens with a low start bit
// - data bits go and come least significant bit first
// - frame closes with a high stop bit
// - line low for a whole frame or longer is a break
// - optional hardware parity, odd or even, in the top data bit
// - receiver flags parity mismatch in hardware
// - baud generator is a 13-bit modulus counter
// - baud generator runs from the module clock only
// - divisor 26 at 4 mhz or 52 at 8 mhz gives 9600 baud
// - receiver-active interrupt only in wait with pll supply high and enabled
// - two independent channels, each with own generator, tx and rx
// - single-wire mode uses one pin and frees the other
// - bit rate is clock over sixteen times the 13-bit divisor
// - generator off until te or re first set, and at divisor zero
// - format bit picks eight or nine data bits
module asfb_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic wait_mode,
  input wire logic pll_supply_level,
  input wire logic [1:0] rxd_i,
  input wire logic [1:0] txd_i,
  output logic [1:0] txd_o,
  output logic [1:0] txd_oe,
  output logic [1:0] rxd_pin_free
);
  import asfb_pkg::*;

  function automatic logic ofs_known(input logic [4:0] o);
    return (o == `ASFB_OFS_BAUD) || (o == `ASFB_OFS_CTRL) || (o == `ASFB_OFS_STAT) ||
      (o == `ASFB_OFS_MASK) || (o == `ASFB_OFS_DATA);
  endfunction

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic [1:0] txd_o_r;
  logic [1:0] txd_oe_r;
  logic [1:0] free_r;

  wire access = psel && penable && !pready_r;
  wire taken = psel && penable && pready_r;
  wire [4:0] ofs = paddr[4:0];
  wire ch_sel = paddr[`ASFB_CH_SEL_BIT];
  wire hit = (paddr[7:6] == 2'b00) && ofs_known(ofs);
  wire wr_en = taken && pwrite && hit;
  wire rd_stat = taken && !pwrite && hit && (ofs == `ASFB_OFS_STAT);

  logic [31:0] rd_ch [2];
  logic [1:0] txd_w;
  logic [1:0] oe_nxt;
  logic [1:0] loops_w;
  logic [1:0] irq_ch;

  // one register per channel group; both groups share decode
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [12:0] baud_r;
    logic [8:0] ctrl_r;
    logic [6:0] stat_r;
    logic [6:0] stat_nxt;
    logic [6:0] mask_r;
    logic [6:0] ev;
    logic [6:0] clr;
    logic [8:0] rdat_r;
    logic act_d_r;
    asfb_cfg_t cfg;
    asfb_rx_t rxw;
    logic txd_c;
    logic busy;
    logic done;
    logic rv;
    logic act;
    logic rx_in;
    logic wake;
    logic tx_load;
    wire me = (ch_sel == 1'(i));
    wire wr_baud = wr_en && me && (ofs == `ASFB_OFS_BAUD);
    wire wr_ctrl = wr_en && me && (ofs == `ASFB_OFS_CTRL);
    wire wr_mask = wr_en && me && (ofs == `ASFB_OFS_MASK);
    wire wr_data = wr_en && me && (ofs == `ASFB_OFS_DATA);
    wire loops = ctrl_r[`ASFB_C_LOOPS];
    wire rsrc = ctrl_r[`ASFB_C_RSRC];

    assign cfg.div = baud_r;
    assign cfg.te = ctrl_r[`ASFB_C_TE];
    assign cfg.re = ctrl_r[`ASFB_C_RE];
    assign cfg.nine = ctrl_r[`ASFB_C_NINE];
    assign cfg.pe = ctrl_r[`ASFB_C_PE];
    assign cfg.pt = ctrl_r[`ASFB_C_PT];
    assign cfg.sbk = ctrl_r[`ASFB_C_SBK];

    // writes while busy are dropped; software polls the busy bit
    assign tx_load = wr_data && cfg.te && !busy;
    // loop feeds tx internally, single wire listens on the tx pin
    assign rx_in = loops ? (rsrc ? txd_i[i] : txd_c) : rxd_i[i];
    // receiver-active rising edge only counts in wait with pll supply up
    assign wake = wait_mode && pll_supply_level && act && !act_d_r;
    assign ev[`ASFB_S_RXF] = rv;
    assign ev[`ASFB_S_TXD] = done;
    assign ev[`ASFB_S_PERR] = rv && rxw.perr;
    assign ev[`ASFB_S_FERR] = rv && rxw.ferr;
    assign ev[`ASFB_S_OVR] = rv && stat_r[`ASFB_S_RXF];
    assign ev[`ASFB_S_BRK] = rv && rxw.brk;
    assign ev[`ASFB_S_WAKE] = wake;
    // clear only bits that were shown; new events win over the clear
    assign clr = (rd_stat && me) ? prdata_r[6:0] : 7'h00;
    assign stat_nxt = (stat_r & ~clr) | ev;

    asfb_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg),
      .tx_load(tx_load),
      .tx_data(pwdata[8:0]),
      .rxd(rx_in),
      .txd(txd_c),
      .tx_busy(busy),
      .tx_done(done),
      .rx_word(rxw),
      .rx_valid(rv),
      .rx_active(act)
    );

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        baud_r <= `ASFB_BAUD_RST;
        ctrl_r <= `ASFB_CTRL_RST;
        mask_r <= `ASFB_MASK_RST;
      end else begin
        if (wr_baud) baud_r <= pwdata[12:0];
        if (wr_ctrl) ctrl_r <= pwdata[8:0];
        if (wr_mask) mask_r <= pwdata[6:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stat_r <= `ASFB_STAT_RST;
        rdat_r <= 9'h000;
        act_d_r <= 1'b0;
      end else begin
        stat_r <= stat_nxt;
        act_d_r <= act;
        // on overrun the older character is kept
        if (rv && !stat_r[`ASFB_S_RXF]) rdat_r <= rxw.data;
      end
    end

    assign rd_ch[i] =
      (ofs == `ASFB_OFS_BAUD) ? {19'h0_0000, baud_r} :
      (ofs == `ASFB_OFS_CTRL) ? {23'h00_0000, ctrl_r} :
      (ofs == `ASFB_OFS_STAT) ? {22'h00_0000, busy, act, 1'b0, stat_r} :
      (ofs == `ASFB_OFS_MASK) ? {25'h000_0000, mask_r} :
      (ofs == `ASFB_OFS_DATA) ? {23'h00_0000, rdat_r} : 32'h0000_0000;
    // receiver-active wake also needs the receiver interrupt enable
    assign irq_ch[i] = |(stat_r & mask_r & {ctrl_r[`ASFB_C_RIE], 6'h3f});
    assign txd_w[i] = txd_c;
    assign loops_w[i] = loops;
    // internal loop hides tx; single wire drives the pin only mid-frame
    assign oe_nxt[i] = cfg.te && (!loops || (rsrc && busy));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= access;
      pslverr_r <= access && !hit;
      prdata_r <= (access && !pwrite && hit) ? rd_ch[ch_sel] : 32'h0000_0000;
    end
  end

  // pins are re-timed so every output leaves from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
      txd_o_r <= 2'b11;
      txd_oe_r <= 2'b00;
      free_r <= 2'b00;
    end else begin
      irq_r <= |irq_ch;
      txd_o_r <= txd_w;
      txd_oe_r <= oe_nxt;
      free_r <= loops_w;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign txd_o = txd_o_r;
  assign txd_oe = txd_oe_r;
  assign rxd_pin_free = free_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait");
  a_parity_err_set: assert property (g_ch[1].rv && g_ch[1].rxw.perr
    |=> g_ch[1].stat_r[`ASFB_S_PERR])
    else $error("parity error not flagged");
  a_wake_only_wait: assert property ($rose(g_ch[1].stat_r[`ASFB_S_WAKE])
    |-> $past(wait_mode) && $past(pll_supply_level))
    else $error("receiver-active wake outside wait or with pll supply low");
  a_pin_freed: assert property (g_ch[0].loops |=> rxd_pin_free[0])
    else $error("single wire mode did not free the rx pin");
  a_irq_follows: assert property (g_ch[1].stat_r[`ASFB_S_RXF] && g_ch[1].mask_r[`ASFB_S_RXF]
    |=> irq)
    else $error("unmasked status did not raise irq");
  a_chan_isolate: assert property (g_ch[0].wr_baud |=> $stable(g_ch[1].baud_r))
    else $error("channel zero write disturbed channel one");
  c_irq_rise: cover property ($rose(irq));
  c_wake_seen: cover property (g_ch[1].wake);
  c_overrun: cover property (g_ch[1].ev[`ASFB_S_OVR]);
endmodule

/* File: dv/asfb_peer.sv */
// far-side serial partner: sends frames onto the rx line, decodes the tx line
// assumes levels change only at pclk edges; bit time is given in pclk cycles
`timescale 1ns/10ps
module asfb_peer (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // stp low with zero data turns the frame into ten or eleven zeros, a break
  task automatic send(input logic [8:0] d, input int nb, input int bt, input logic stp);
    line_out <= 1'b0;
    repeat (bt) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (bt) @(posedge pclk);
    end
    line_out <= stp;
    repeat (bt) @(posedge pclk);
    line_out <= 1'b1;
    @(posedge pclk);
  endtask
  // samples at bit centres, so a wrong bit time shows as wrong data
  task automatic recv(input int nb, input int bt, output logic [8:0] d, output logic st0,
                      output logic stp);
    d = '0;
    while (line_in !== 1'b0) @(posedge pclk);
    repeat (bt / 2) @(posedge pclk);
    st0 = line_in;
    for (int i = 0; i < nb; i++) begin
      repeat (bt) @(posedge pclk);
      d[i] = line_in;
    end
    repeat (bt) @(posedge pclk);
    stp = line_in;
  endtask
endmodule

/* File: dv/tb.sv */
// self-checking bench for the two-channel serial block
// assumes the partner model and the design files are compiled first
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} asfb_row_t;
  typedef struct {logic [8:0] c; logic [8:0] d; int nb; logic [8:0] ex;} asfb_txrow_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic wait_mode = 1'b1;
  logic pll_supply_level = 1'b1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, er, s0, sp, peer_line;
  logic [1:0] rxd_i, txd_i, txd_o, txd_oe, rxd_pin_free;
  logic [8:0] got;
  int err_total = 0;
  int n_compared = 0;
  asfb_row_t regs[4] = '{'{8'h00, 32'hffff_ffff, 32'h0000_1fff},
    '{8'h24, 32'hffff_fe00, 32'h0000_0000}, '{8'h0c, 32'hffff_ff80, 32'h0000_0000},
    '{8'h2c, 32'hffff_ffff, 32'h0000_007f}};
  asfb_txrow_t txr[5] = '{'{9'h001, 9'h0a5, 8, 9'h0a5}, '{9'h009, 9'h035, 8, 9'h035},
    '{9'h019, 9'h035, 8, 9'h0b5}, '{9'h005, 9'h1a5, 9, 9'h1a5}, '{9'h01d, 9'h0f3, 9, 9'h1f3}};
  always #50 pclk = ~pclk;
  // tx pin pulled up while nobody drives it
  assign txd_i = txd_o | ~txd_oe;
  assign rxd_i = {2{peer_line}};
  asfb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .wait_mode(wait_mode), .pll_supply_level(pll_supply_level),
    .rxd_i(rxd_i), .txd_i(txd_i), .txd_o(txd_o), .txd_oe(txd_oe), .rxd_pin_free(rxd_pin_free));
  asfb_peer peer (.pclk(pclk), .line_in(txd_i[0]), .line_out(peer_line));
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here; the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex,
                      input string nm);
    apb(a, 1'b0, 32'h0000_0000);
    `CHK(nm, ex, rd & m)
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("txd idle", 2'b11, txd_o)
    `CHK("irq reset", 1'b0, irq)
    @(posedge pclk);
    for (int c = 0; c < 2; c++) begin
      for (int o = 0; o < 5; o++) rchk(8'(32 * c + 4 * o), 32'hffff_ffff, 0, "reset value");
    end
    foreach (regs[i]) begin
      apb(regs[i].a, 1'b1, regs[i].w);
      rchk(regs[i].a, 32'hffff_ffff, regs[i].r, "readback");
    end
    apb(8'h14, 1'b0, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, er)
    apb(8'h40, 1'b0, 32'h0000_0000);
    `CHK("high addr err", 1'b1, er)
    apb(8'h00, 1'b1, 32'h0000_0001);
    foreach (txr[i]) begin
      apb(8'h04, 1'b1, {23'h0, txr[i].c});
      fork
        apb(8'h10, 1'b1, {23'h0, txr[i].d});
        peer.recv(txr[i].nb, 16, got, s0, sp);
      join
      `CHK("tx start", 1'b0, s0)
      `CHK("tx data", txr[i].ex, got)
      `CHK("tx stop", 1'b1, sp)
      repeat (20) @(posedge pclk);
      rchk(8'h08, 32'h0000_0002, 32'h0000_0002, "tx done");
    end
    apb(8'h04, 1'b1, 32'h0000_0081);
    peer.recv(8, 16, got, s0, sp);
    apb(8'h04, 1'b1, 32'h0000_0001);
    `CHK("break data", 9'h000, got)
    `CHK("break stop", 1'b0, sp)
    `CHK("tx drive", 2'b01, txd_oe)
    rchk(8'h28, 32'h0000_0002, 32'h0000_0000, "other channel quiet");
    apb(8'h2c, 1'b1, 32'h0000_0000);
    apb(8'h20, 1'b1, 32'h0000_0003);
    apb(8'h24, 1'b1, 32'h0000_0002);
    peer.send(9'h0c3, 8, 48, 1'b1);
    repeat (4) @(posedge pclk);
    `CHK("irq masked", 1'b0, irq)
    rchk(8'h28, 32'h0000_007f, 32'h0000_0041, "rx wake status");
    rchk(8'h30, 32'h0000_01ff, 32'h0000_00c3, "rx data");
    pll_supply_level <= 1'b0;
    peer.send(9'h05a, 8, 48, 1'b1);
    rchk(8'h28, 32'h0000_007f, 32'h0000_0001, "rx no wake");
    wait_mode <= 1'b0;
    pll_supply_level <= 1'b1;
    apb(8'h24, 1'b1, 32'h0000_000a);
    peer.send(9'h001, 8, 48, 1'b1);
    rchk(8'h28, 32'h0000_0044, 32'h0000_0004, "even parity err");
    apb(8'h24, 1'b1, 32'h0000_001a);
    peer.send(9'h001, 8, 48, 1'b1);
    rchk(8'h28, 32'h0000_0004, 32'h0000_0000, "odd parity ok");
    apb(8'h24, 1'b1, 32'h0000_0002);
    peer.send(9'h000, 8, 48, 1'b0);
    rchk(8'h28, 32'h0000_0028, 32'h0000_0028, "break");
    apb(8'h2c, 1'b1, 32'h0000_0001);
    peer.send(9'h011, 8, 48, 1'b1);
    repeat (4) @(posedge pclk);
    `CHK("irq raised", 1'b1, irq)
    rchk(8'h28, 32'h0000_0001, 32'h0000_0001, "rx full");
    repeat (3) @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    apb(8'h04, 1'b1, 32'h0000_0023);
    repeat (3) @(posedge pclk);
    `CHK("rx pin freed", 2'b01, rxd_pin_free)
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK("pin free reset", 2'b00, rxd_pin_free)
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(8'h04, 32'hffff_ffff, 32'h0000_0000, "ctrl after reset");
    `CHK("txd idle again", 2'b11, txd_o)
    `CHK("oe after reset", 2'b00, txd_oe)
    results();
  end
  // whole run is a few thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    results();
  end
endmodule
